// [hdl/usb_function_power_control.sv]
// power and enable control of the usb function unit, apb slave registers
// assumes bus events arrive as one-cycle pulses from logic on CLK
//
// Summary of operation
// R1: iso update holds ready packet until sof
// R2: in token before sof gets zero-length
// R3: inhibit set by power-on and forced reset
// R4: software writing one to inhibit ignored
// R5: inhibit high blocks all bus traffic
// R6: software clears inhibit after transceiver setup
// R7: suspend status high while suspended
// R8: resume write zero clears suspend status
// R9: common flag read after resume clears suspend
// R10: reset detect flag; write one forces reset
// R11: resume one drives remote wakeup signalling
// R12: suspend entered only when detect enabled
// R13: bits six and five read zero
// R14: suspend resume reset raise interrupt flags
`timescale 1ns/100ps
`include "usb_power_regs.svh"
module usb_function_power_control
    import usb_power_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // bus events from the line monitor
    input wire bus_event_type BUS_EVENT,
    // in endpoint handshake
    input wire logic IN_PACKET_READY,
    output logic SEND_PACKET,
    output logic SEND_ZERO_LENGTH,
    // line control and status
    output logic FUNCTION_ENABLE,
    output logic DRIVE_RESUME,
    output logic FUNCTION_RESET,
    output logic SUSPENDED,
    // interrupt
    output logic IRQ
);

    //**********************************************************************
    // bus access decode
    //**********************************************************************

    logic wr_en;
    logic rd_en;
    logic force_reset_reg;
    logic rst_any;
    logic iso_update_reg;
    logic inhibit_reg;
    logic reset_det_reg;
    logic resume_reg;
    logic suspend_reg;
    logic suspend_en_reg;
    logic resume_seen_reg;
    logic [3:0] irq_status_reg;
    logic [3:0] irq_status_next;
    logic [3:0] irq_mask_reg;
    logic [3:0] common_interrupt_flags_reg;
    logic [3:0] common_interrupt_flags_next;
    logic [31:0] rdata_next;
    logic ctrl_wr;
    logic common_interrupt_flags_rd;
    bus_event_type ev;
    iso_state_type iso_state_reg;
    iso_state_type iso_state_next;

    // one-cycle access phase, always ready
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;
    assign PREADY = 1'b1;
    assign ctrl_wr = wr_en && (PADDR == `PWR_CTRL_ADDR);
    assign common_interrupt_flags_rd = rd_en && (PADDR == `PWR_COMMON_INTERRUPT_FLAGS_ADDR);

    // unmapped addresses answer with an error
    always_comb begin
        PSLVERR = 1'b0;
        if (PSEL && PENABLE) begin
            PSLVERR = !((PADDR == `PWR_CTRL_ADDR) ||
                (PADDR == `PWR_IRQ_STATUS_ADDR) ||
                (PADDR == `PWR_IRQ_MASK_ADDR) ||
                (PADDR == `PWR_COMMON_INTERRUPT_FLAGS_ADDR));
        end
    end

    //**********************************************************************
    // reset and bus gating
    //**********************************************************************

    // forced function reset acts as a second reset source for one cycle
    assign rst_any = !RST_N || force_reset_reg; // R3
    assign FUNCTION_RESET = force_reset_reg;

    // inhibited function sees no bus events at all
    assign ev = inhibit_reg ? '0 : BUS_EVENT; // R5

    // a write of one to reset detect triggers the forced reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            force_reset_reg <= 1'b0;
        end else begin
            force_reset_reg <= ctrl_wr && PWDATA[`BIT_RESET_DET]; // R10
        end
    end

    //**********************************************************************
    // control register
    //**********************************************************************

    // software fields; inhibit can only be cleared by software
    always_ff @(posedge CLK) begin
        if (rst_any) begin
            iso_update_reg <= 1'b0;
            inhibit_reg <= 1'b1; // R3
            resume_reg <= 1'b0;
            suspend_en_reg <= 1'b0;
        end else if (ctrl_wr) begin
            iso_update_reg <= PWDATA[`BIT_ISO_UPDATE];
            inhibit_reg <= inhibit_reg && PWDATA[`BIT_INHIBIT]; // R4
            resume_reg <= PWDATA[`BIT_RESUME]; // R11
            suspend_en_reg <= PWDATA[`BIT_SUSPEND_EN];
        end
    end

    // reset detect flag, set by reset signalling on the bus
    always_ff @(posedge CLK) begin
        if (rst_any) begin
            reset_det_reg <= 1'b0;
        end else if (ev.reset) begin
            reset_det_reg <= 1'b1; // R10
        end else if (ctrl_wr && !PWDATA[`BIT_RESET_DET]) begin
            reset_det_reg <= 1'b0;
        end
    end

    //**********************************************************************
    // suspend state
    //**********************************************************************

    // enter on suspend signalling when enabled, leave on resume or reset
    always_ff @(posedge CLK) begin
        if (rst_any) begin
            suspend_reg <= 1'b0;
            resume_seen_reg <= 1'b0;
        end else begin
            if (ev.resume) begin
                resume_seen_reg <= 1'b1;
            end else if (common_interrupt_flags_rd) begin
                resume_seen_reg <= 1'b0;
            end
            if (ev.reset) begin
                suspend_reg <= 1'b0; // R14
            end else if (suspend_en_reg && ev.suspend) begin
                suspend_reg <= 1'b1; // R7 R12
            end else if (ctrl_wr && resume_reg &&
                !PWDATA[`BIT_RESUME]) begin
                suspend_reg <= 1'b0; // R8
            end else if (common_interrupt_flags_rd && resume_seen_reg) begin
                suspend_reg <= 1'b0; // R9
            end
        end
    end

    //**********************************************************************
    // interrupt flags
    //**********************************************************************

    // common flags: set by events, cleared by reading, set wins
    always_comb begin
        common_interrupt_flags_next = common_interrupt_flags_reg;
        if (common_interrupt_flags_rd) begin
            common_interrupt_flags_next = 4'h0;
        end
        if (suspend_en_reg && ev.suspend && !suspend_reg) begin
            common_interrupt_flags_next[`IRQ_SUSPEND] = 1'b1; // R14
        end
        if (ev.resume) begin
            common_interrupt_flags_next[`IRQ_RESUME] = 1'b1; // R14
        end
        if (ev.reset) begin
            common_interrupt_flags_next[`IRQ_RESET] = 1'b1; // R14
        end
        if (ev.sof) begin
            common_interrupt_flags_next[`IRQ_SOF] = 1'b1;
        end
    end

    // sticky status, write one to clear, set wins over clear
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_en && (PADDR == `PWR_IRQ_STATUS_ADDR)) begin
            irq_status_next = irq_status_reg & ~PWDATA[3:0];
        end
        irq_status_next = irq_status_next | (common_interrupt_flags_next & ~common_interrupt_flags_reg);
    end

    always_ff @(posedge CLK) begin
        if (rst_any) begin
            common_interrupt_flags_reg <= 4'h0;
            irq_status_reg <= 4'h0;
            irq_mask_reg <= `IRQ_MASK_RESET;
        end else begin
            common_interrupt_flags_reg <= common_interrupt_flags_next;
            irq_status_reg <= irq_status_next;
            if (wr_en && (PADDR == `PWR_IRQ_MASK_ADDR)) begin
                irq_mask_reg <= PWDATA[3:0];
            end
        end
    end

    // level interrupt while any unmasked status bit is set
    assign IRQ = |(irq_status_reg & irq_mask_reg);

    //**********************************************************************
    // iso in update gate
    //**********************************************************************

    // hold a ready packet until sof; in token before sof gets zero length
    always_comb begin
        iso_state_next = iso_state_reg;
        unique case (iso_state_reg)
            ISO_IDLE: begin
                if (IN_PACKET_READY && iso_update_reg) begin
                    iso_state_next = ISO_HOLD; // R1
                end else if (IN_PACKET_READY) begin
                    iso_state_next = ISO_ARMED;
                end
            end
            ISO_HOLD: begin
                if (ev.sof) begin
                    iso_state_next = ISO_ARMED; // R1
                end
            end
            ISO_ARMED: begin
                if (ev.in_token) begin
                    iso_state_next = ISO_IDLE;
                end
            end
            default: begin
                iso_state_next = ISO_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (rst_any) begin
            iso_state_reg <= ISO_IDLE;
            SEND_PACKET <= 1'b0;
            SEND_ZERO_LENGTH <= 1'b0;
        end else begin
            iso_state_reg <= iso_state_next;
            SEND_PACKET <= (iso_state_reg == ISO_ARMED) && ev.in_token;
            SEND_ZERO_LENGTH <= (iso_state_reg != ISO_ARMED) &&
                ev.in_token; // R2
        end
    end

    //**********************************************************************
    // read data and status outputs
    //**********************************************************************

    // unused bits six and five always read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (PADDR)
            `PWR_CTRL_ADDR: begin
                rdata_next[7:0] = {iso_update_reg, 2'b00, inhibit_reg,
                    reset_det_reg, resume_reg, suspend_reg,
                    suspend_en_reg}; // R13
            end
            `PWR_IRQ_STATUS_ADDR: begin
                rdata_next[3:0] = irq_status_reg;
            end
            `PWR_IRQ_MASK_ADDR: begin
                rdata_next[3:0] = irq_mask_reg;
            end
            `PWR_COMMON_INTERRUPT_FLAGS_ADDR: begin
                rdata_next[3:0] = common_interrupt_flags_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // read data registered in setup phase, valid in access phase
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE) begin
            PRDATA <= rdata_next;
        end
    end

    assign FUNCTION_ENABLE = !inhibit_reg;
    assign DRIVE_RESUME = resume_reg; // R11
    assign SUSPENDED = suspend_reg;

endmodule : usb_function_power_control

// [inc/usb_power_pkg.sv]
// types shared by the power control block and its bench
// assumes usb_power_regs.svh is on the include path
package usb_power_pkg;
    // events seen on the bus by the line monitor
    typedef struct packed {
        logic sof;
        logic in_token;
        logic suspend;
        logic resume;
        logic reset;
    } bus_event_type;
    // iso in gate states
    typedef enum logic [2:0] {
        ISO_IDLE = 3'b001,
        ISO_HOLD = 3'b010,
        ISO_ARMED = 3'b100
    } iso_state_type;
endpackage : usb_power_pkg

// [inc/usb_power_regs.svh]
// offsets, field positions and reset values of the power block
// assumes inclusion by bare name from design, bench and checker files
`ifndef USB_POWER_REGS_SVH
`define USB_POWER_REGS_SVH
// register index 0x01 is a word index: byte address is four times index
`define PWR_CTRL_INDEX 8'h01
`define PWR_CTRL_ADDR 12'h004
`define PWR_IRQ_STATUS_ADDR 12'h010
`define PWR_IRQ_MASK_ADDR 12'h014
`define PWR_COMMON_INTERRUPT_FLAGS_ADDR 12'h018
// control register fields
`define BIT_ISO_UPDATE 7
`define BIT_INHIBIT 4
`define BIT_RESET_DET 3
`define BIT_RESUME 2
`define BIT_SUSPEND 1
`define BIT_SUSPEND_EN 0
// interrupt fields (status, mask and common flags share this layout)
`define IRQ_SUSPEND 0
`define IRQ_RESUME 1
`define IRQ_RESET 2
`define IRQ_SOF 3
// reset values
`define PWR_CTRL_RESET 8'h10
`define IRQ_MASK_RESET 4'h0
`endif

// [sim/usb_function_power_control_tb.sv]
// self-checking bench of the usb power control block
// assumes the host model and checker are compiled before it
`timescale 1ns/100ps
`include "usb_power_regs.svh"
module usb_function_power_control_tb
    import usb_power_pkg::*;
;
    localparam int EV_SOF = 4, EV_IN = 3, EV_SUSP = 2, EV_RES = 1, EV_RST = 0;
    localparam logic [11:0] CTRL = `PWR_CTRL_ADDR, STAT = `PWR_IRQ_STATUS_ADDR;
    localparam logic [11:0] MASK = `PWR_IRQ_MASK_ADDR, COMMON_INTERRUPT_FLAGS = `PWR_COMMON_INTERRUPT_FLAGS_ADDR;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, in_rdy = 1'b0, pready, pslverr, send_pkt, send_zero;
    logic fn_en, drv_res, fn_rst, susp, irq;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    bus_event_type bus_ev;
    int mismatches = 0, checks_done = 0, n_pkt = 0, n_zero = 0;
    // ****************************************
    // clock, design, host and packet counters
    // ****************************************
    always #20 clk = ~clk;
    usb_function_power_control dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .BUS_EVENT(bus_ev), .IN_PACKET_READY(in_rdy), .SEND_PACKET(send_pkt),
        .SEND_ZERO_LENGTH(send_zero), .FUNCTION_ENABLE(fn_en),
        .DRIVE_RESUME(drv_res), .FUNCTION_RESET(fn_rst), .SUSPENDED(susp),
        .IRQ(irq));
    usb_host_model host (.CLK(clk), .BUS_EVENT(bus_ev));
    // count packets and zero-length answers sent toward the host
    always @(posedge clk) begin
        n_pkt += (send_pkt === 1'b1);
        n_zero += (send_zero === 1'b1);
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            mismatches++;
            wrap_up();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, '0, q, e);
        check(q, exp);
    endtask : rd
    task automatic ev(input int idx);
        host.signal(idx);
        repeat (3) @(posedge clk);
    endtask : ev
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_enable;
        rd(CTRL, 32'h10);
        rd(MASK, 32'h0);
        ev(EV_IN);
        check(n_zero + n_pkt, 0);
        wr(CTRL, 32'h70);
        rd(CTRL, 32'h10);
        wr(CTRL, 32'h00);
        wr(CTRL, 32'h10);
        rd(CTRL, 32'h00);
        @(negedge clk);
        check(fn_en, 1);
        $display("enable test done");
    endtask : t_enable
    task automatic t_iso;
        wr(CTRL, 32'h80);
        @(posedge clk);
        in_rdy <= 1'b1;
        @(posedge clk);
        in_rdy <= 1'b0;
        ev(EV_IN);
        check(n_zero, 1);
        check(n_pkt, 0);
        ev(EV_SOF);
        ev(EV_IN);
        check(n_pkt, 1);
        rd(COMMON_INTERRUPT_FLAGS, 32'h8);
        rd(STAT, 32'h8);
        wr(STAT, 32'hf);
        rd(STAT, 32'h0);
        $display("iso test done");
    endtask : t_iso
    task automatic t_suspend;
        logic [31:0] q;
        logic e;
        ev(EV_SUSP);
        @(negedge clk);
        check(susp, 0);
        wr(CTRL, 32'h01);
        ev(EV_SUSP);
        @(negedge clk);
        check(susp, 1);
        rd(STAT, 32'h1);
        wr(MASK, 32'h1);
        @(negedge clk);
        check(irq, 1);
        wr(STAT, 32'h1);
        @(negedge clk);
        check(irq, 0);
        ev(EV_RES);
        rd(COMMON_INTERRUPT_FLAGS, 32'h3);
        @(negedge clk);
        check(susp, 0);
        ev(EV_SUSP);
        wr(CTRL, 32'h05);
        @(negedge clk);
        check({drv_res, susp}, 2'b11);
        wr(CTRL, 32'h01);
        @(negedge clk);
        check({drv_res, susp}, 2'b00);
        apb(1'b0, 12'h020, '0, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        $display("suspend test done");
    endtask : t_suspend
    task automatic t_reset;
        ev(EV_RST);
        rd(CTRL, 32'h09);
        wr(CTRL, 32'h08);
        rd(CTRL, 32'h10);
        rd(MASK, 32'h0);
        $display("reset test done");
    endtask : t_reset
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_enable();
        t_iso();
        t_suspend();
        t_reset();
        wrap_up();
    end
endmodule : usb_function_power_control_tb

// [sim/usb_host_model.sv]
// host side of the usb bus, as seen by the line monitor events
// assumes the caller enters signal right after a rising edge
`timescale 1ns/100ps
module usb_host_model
    import usb_power_pkg::*;
(
    // clock
    input wire logic CLK,
    // bus events toward the function
    output bus_event_type BUS_EVENT
);
    initial BUS_EVENT = '0;
    // one-cycle pulse of one bus event: sof, token or line state
    task automatic signal(input int idx);
        bus_event_type ev;
        ev = '0;
        ev[idx] = 1'b1;
        @(posedge CLK);
        BUS_EVENT <= ev;
        @(posedge CLK);
        BUS_EVENT <= '0;
    endtask : signal
endmodule : usb_host_model

// [sim/usb_power_asserts.sv]
// concurrent checks on the ports of the power control block
// assumes it is bound onto usb_function_power_control
`timescale 1ns/100ps
`include "usb_power_regs.svh"
module usb_power_asserts
    import usb_power_pkg::*;
(
    // clock, reset and apb
    input wire logic CLK, RST_N, PSEL, PENABLE, PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA, PRDATA,
    input wire logic PREADY, PSLVERR,
    // bus side and line status
    input wire bus_event_type BUS_EVENT,
    input wire logic IN_PACKET_READY, SEND_PACKET, SEND_ZERO_LENGTH,
    input wire logic FUNCTION_ENABLE, DRIVE_RESUME, FUNCTION_RESET,
    input wire logic SUSPENDED, IRQ
);
    // ****************************************
    // clocking and decoded write and read
    // ****************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic ctrl_wr;
    logic common_interrupt_flags_rd;
    // access cycles that touch control or common flags
    assign ctrl_wr = PSEL && PENABLE && PWRITE && PADDR == `PWR_CTRL_ADDR;
    assign common_interrupt_flags_rd = PSEL && PENABLE && !PWRITE && PADDR == `PWR_COMMON_INTERRUPT_FLAGS_ADDR;
    a_inhibit_blocks: assert property (
        !FUNCTION_ENABLE && BUS_EVENT.in_token |=>
        !SEND_PACKET && !SEND_ZERO_LENGTH) else $error("traffic while off");
    a_zero_cause: assert property (
        SEND_ZERO_LENGTH |-> !SEND_PACKET &&
        $past(BUS_EVENT.in_token && FUNCTION_ENABLE)) else $error("bad zlp");
    a_send_cause: assert property (
        SEND_PACKET |-> $past(BUS_EVENT.in_token && FUNCTION_ENABLE))
        else $error("send without token");
    a_inhibit_sticky: assert property (
        FUNCTION_ENABLE && !FUNCTION_RESET |=> FUNCTION_ENABLE)
        else $error("inhibit set by software");
    a_forced_reset: assert property (
        FUNCTION_RESET |=> !FUNCTION_ENABLE && !SUSPENDED && !DRIVE_RESUME)
        else $error("forced reset incomplete");
    a_write_reset: assert property (
        ctrl_wr && PWDATA[3] |=> FUNCTION_RESET ##1 !FUNCTION_RESET)
        else $error("no reset pulse");
    a_resume_drive: assert property (
        ctrl_wr && !PWDATA[3] |=> DRIVE_RESUME == $past(PWDATA[2]))
        else $error("resume drive wrong");
    a_suspend_rise: assert property (
        $rose(SUSPENDED) |-> $past(BUS_EVENT.suspend && FUNCTION_ENABLE))
        else $error("suspend without cause");
    a_suspend_fall: assert property (
        $fell(SUSPENDED) |-> $past(BUS_EVENT.reset || FUNCTION_RESET ||
        common_interrupt_flags_rd || ctrl_wr && !PWDATA[2])) else $error("suspend lost");
endmodule : usb_power_asserts
bind usb_function_power_control usb_power_asserts chk (.*);
